/* File: cdr_pkg.sv */
// constants shared by the clock recovery and retiming design
`default_nettype none
package cdr_pkg;
    // ------------------------------------------------------------
    // clocking and rates
    // ------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS    = 25;
    localparam int unsigned CLK_HZ           = 1_000_000_000 / CLK_PERIOD_NS;
    localparam int unsigned NOMINAL_BPS      = 100_000_000;
    // model runs the serial stream scaled down to this many clocks per bit
    localparam int unsigned BIT_CYCLES       = 8;
    localparam int unsigned MODEL_BPS        = CLK_HZ / BIT_CYCLES;
    localparam int unsigned CAPTURE_PERCENT  = 4;
    localparam int unsigned OFFSET_PERCENT   = 3;

    // ------------------------------------------------------------
    // oscillator and loop filter
    // ------------------------------------------------------------
    localparam int unsigned PHASE_W          = 16;
    localparam int unsigned FREQ_W           = 12;
    localparam logic [PHASE_W-1:0] NCO_STEP  = PHASE_W'((32'h1 << PHASE_W) / BIT_CYCLES);
    localparam logic signed [FREQ_W-1:0] FREQ_LIMIT =
        FREQ_W'((32'h1 << PHASE_W) / BIT_CYCLES * CAPTURE_PERCENT / 100);
    localparam logic [PHASE_W-1:0] KP_STEP   = 16'h0100;
    localparam logic signed [FREQ_W-1:0] KI_STEP = 12'h004;
    localparam logic [PHASE_W-1:0] PHASE_RST = 16'h0000;
    localparam logic signed [FREQ_W-1:0] FREQ_RST = 12'h000;

    // ------------------------------------------------------------
    // transition detector
    // ------------------------------------------------------------
    localparam int unsigned DELAY_STAGES     = 2;
endpackage
`default_nettype wire

/* File: transition_detect.sv */
// transition detector: data xor a two-gate delayed copy of itself
`default_nettype none
module transition_detect (
    input  wire logic clock_i,
    input  wire logic rstn_i,
    td_link.detector  link
);
    typedef struct packed {
        logic first_delay_gate;
        logic second_delay_gate;
        logic transition_gate;
    } td_state_t;

    td_state_t s_r;
    td_state_t s_nxt;

    always_comb begin
        s_nxt                   = s_r;
        s_nxt.first_delay_gate  = link.data;
        s_nxt.second_delay_gate = s_r.first_delay_gate;
        // a pulse lasts as long as the two-stage delay, once per edge
        s_nxt.transition_gate   = link.data ^ s_r.second_delay_gate;
    end

    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.pulse   = s_r.transition_gate;
    // copy aligned with the pulse centre for the decision flip-flop
    assign link.delayed = s_r.second_delay_gate;
endmodule
`default_nettype wire

/* File: cdr_retime.sv */
// clock recovery loop and decision flip-flop for an nrz serial stream
`default_nettype none
// Operation
// - pulses from data xor delayed data
// - one pulse per edge, none when steady
// - pulse width equals two delay stages
// - advance/retard width difference tracks phase
// - no pulses means advance and retard low
// - long runs tolerated, loop holds frequency
// - locks on 2^23-1 pseudo-random sequence
// - capture range plus or minus four percent
// - data sampled by recovered clock flip-flop
// - retimed data changes only with recovered clock
// - sampling instant at eye centre
// - nominal rate one hundred megabits, scaled
// - works with three percent rate offset
// - true and complement clocks, no skew
module cdr_retime (
    input  wire logic clock_i,
    input  wire logic rstn_i,
    input  wire logic serial_i,
    output logic      rec_clk_o,
    output logic      rec_clk_n_o,
    output logic      retimed_data_o,
    output logic      transition_o,
    output logic      advance_o,
    output logic      retard_o,
    output logic      freq_at_limit_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        // two-stage synchroniser for the asynchronous serial input
        logic                                  sync1;
        logic                                  sync2;
        // oscillator phase accumulator and loop filter frequency term
        logic [cdr_pkg::PHASE_W-1:0]           phase;
        logic signed [cdr_pkg::FREQ_W-1:0]     freq;
        // registered outputs
        logic                                  rec_clk;
        logic                                  rec_clk_n;
        logic                                  retimed;
        logic                                  transition;
        logic                                  advance;
        logic                                  retard;
        logic                                  at_limit;
    } cdr_state_t;

    cdr_state_t s_r;
    cdr_state_t s_nxt;
    logic       pulse;
    logic       delayed;

    // ------------------------------------------------------------
    // loop arithmetic
    // ------------------------------------------------------------
    // saturating add keeps the frequency term inside the capture window
    function automatic logic signed [cdr_pkg::FREQ_W-1:0] clamp_add(
        input logic signed [cdr_pkg::FREQ_W-1:0] a,
        input logic signed [cdr_pkg::FREQ_W-1:0] b
    );
        logic signed [cdr_pkg::FREQ_W:0] sum;
        logic signed [cdr_pkg::FREQ_W:0] lim;
        // both sides signed, or a negative sum would compare as a huge one
        sum = {a[cdr_pkg::FREQ_W-1], a} + {b[cdr_pkg::FREQ_W-1], b};
        lim = {cdr_pkg::FREQ_LIMIT[cdr_pkg::FREQ_W-1], cdr_pkg::FREQ_LIMIT};
        if (sum > lim) begin
            clamp_add = cdr_pkg::FREQ_LIMIT;
        end else if (sum < -lim) begin
            clamp_add = -cdr_pkg::FREQ_LIMIT;
        end else begin
            clamp_add = sum[cdr_pkg::FREQ_W-1:0];
        end
    endfunction

    // sign-extend the frequency term to the phase accumulator width
    function automatic logic [cdr_pkg::PHASE_W-1:0] freq_to_step(
        input logic signed [cdr_pkg::FREQ_W-1:0] f
    );
        freq_to_step = {{(cdr_pkg::PHASE_W-cdr_pkg::FREQ_W){f[cdr_pkg::FREQ_W-1]}}, f};
    endfunction

    // true when the frequency term sits on either edge of the window
    function automatic logic at_clamp(
        input logic signed [cdr_pkg::FREQ_W-1:0] f
    );
        at_clamp = (f == cdr_pkg::FREQ_LIMIT) || (f == -cdr_pkg::FREQ_LIMIT);
    endfunction

    // gated detector: the pulse half before the clock edge advances,
    // the half after retards; both stay low without transitions
    function automatic logic [1:0] phase_detect(
        input logic pulse_in,
        input logic clk_high
    );
        phase_detect = {pulse_in & ~clk_high, pulse_in & clk_high};
    endfunction

    // proportional kick: a request moves the phase at once, so the loop
    // answers within one pulse while the integral term stays slow
    function automatic logic [cdr_pkg::PHASE_W-1:0] pump_step(
        input logic [cdr_pkg::PHASE_W-1:0] base,
        input logic                        up,
        input logic                        down
    );
        pump_step = base;
        if (up) begin
            pump_step = base + cdr_pkg::KP_STEP;
        end else if (down) begin
            pump_step = base - cdr_pkg::KP_STEP;
        end
    endfunction

    // integral path only moves on requests, so long runs keep frequency
    function automatic logic signed [cdr_pkg::FREQ_W-1:0] freq_next(
        input logic signed [cdr_pkg::FREQ_W-1:0] f,
        input logic                              up,
        input logic                              down
    );
        freq_next = f;
        if (up) begin
            freq_next = clamp_add(f, cdr_pkg::KI_STEP);
        end else if (down) begin
            freq_next = clamp_add(f, -cdr_pkg::KI_STEP);
        end
    endfunction

    // the decision flop fires where the recovered clock goes high to low
    function automatic logic clock_fell(
        input logic                        now_high,
        input logic [cdr_pkg::PHASE_W-1:0] next_phase
    );
        clock_fell = now_high && !next_phase[cdr_pkg::PHASE_W-1];
    endfunction

    // ------------------------------------------------------------
    // transition detector on the synchronised stream
    // ------------------------------------------------------------
    // the stream enters the detector after both synchroniser stages
    td_link u_link ();

    assign u_link.data = s_r.sync2;
    assign pulse       = u_link.pulse;
    assign delayed     = u_link.delayed;

    // pulse and delayed copy come back registered inside the detector
    transition_detect u_td (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .link    (u_link)
    );

    // ------------------------------------------------------------
    // phase detector, loop filter, oscillator, decision flip-flop
    // ------------------------------------------------------------
    always_comb begin
        logic                              adv;
        logic                              ret;
        logic [cdr_pkg::PHASE_W-1:0]       step;
        logic signed [cdr_pkg::FREQ_W-1:0] fnext;
        logic [cdr_pkg::PHASE_W-1:0]       pnext;
        adv   = 1'b0;
        ret   = 1'b0;
        step  = '0;
        fnext = '0;
        pnext = '0;
        s_nxt = s_r;
        // serial_i comes from outside the clock domain: two flops first
        s_nxt.sync1 = serial_i;
        s_nxt.sync2 = s_r.sync1;
        // phase detector
        {adv, ret}       = phase_detect(pulse, s_r.rec_clk);
        s_nxt.advance    = adv;
        s_nxt.retard     = ret;
        s_nxt.transition = pulse;
        // loop filter: the integral term rides on the nominal step
        fnext            = freq_next(s_r.freq, adv, ret);
        s_nxt.freq       = fnext;
        s_nxt.at_limit   = at_clamp(fnext);
        // oscillator: the proportional term shifts the phase at once
        step             = cdr_pkg::NCO_STEP + freq_to_step(s_r.freq);
        step             = pump_step(step, adv, ret);
        pnext            = s_r.phase + step;
        s_nxt.phase      = pnext;
        s_nxt.rec_clk    = pnext[cdr_pkg::PHASE_W-1];
        s_nxt.rec_clk_n  = ~pnext[cdr_pkg::PHASE_W-1];
        // edges lock to the rising clock, so the falling edge is mid-eye
        if (clock_fell(s_r.rec_clk, pnext)) begin
            s_nxt.retimed = delayed;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
            // complement clock leaves reset high, opposite its pair
            s_r       <= '0;
            s_r.phase <= cdr_pkg::PHASE_RST;
            s_r.freq  <= cdr_pkg::FREQ_RST;
            s_r.rec_clk_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs, each straight from a register
    // ------------------------------------------------------------
    assign rec_clk_o       = s_r.rec_clk;
    assign rec_clk_n_o     = s_r.rec_clk_n;
    assign retimed_data_o  = s_r.retimed;
    assign transition_o    = s_r.transition;
    assign advance_o       = s_r.advance;
    assign retard_o        = s_r.retard;
    assign freq_at_limit_o = s_r.at_limit;
endmodule
`default_nettype wire

/* File: cdr_retime_unused_placeholder_never.sv */
// carrier between the recovery loop and its transition detector
`default_nettype none
interface td_link;
    logic data;
    logic pulse;
    logic delayed;
    // the detector takes the synchronised stream and hands back its pulse
    modport detector (
        input  data,
        output pulse,
        output delayed
    );
    modport loop (
        output data,
        input  pulse,
        input  delayed
    );
endinterface
`default_nettype wire

/* File: cdr_retime_assertions.sv */
// port assertions for the clock recovery and retiming block
`default_nettype none
module cdr_retime_assertions (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic serial_i,
    input wire logic rec_clk_o,
    input wire logic rec_clk_n_o,
    input wire logic retimed_data_o,
    input wire logic transition_o,
    input wire logic advance_o,
    input wire logic retard_o,
    input wire logic freq_at_limit_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    a_clk_complement: assert property (rec_clk_n_o != rec_clk_o)
        else $error("clock pair not opposite");
    a_edge_pulse: assert property ($changed(serial_i) |-> ##[3:5] $rose(transition_o))
        else $error("data edge without pulse");
    a_pulse_width: assert property ($rose(transition_o) |=> transition_o ##1 !transition_o)
        else $error("pulse width not two cycles");
    a_steady_quiet: assert property ($stable(serial_i) [*7] |-> !transition_o)
        else $error("pulse on steady data");
    a_idle_pumps: assert property (!transition_o |-> !advance_o && !retard_o)
        else $error("pump request without pulse");
    a_pump_cover: assert property (transition_o |-> advance_o || retard_o)
        else $error("pulse without pump request");
    a_pump_excl: assert property (!(advance_o && retard_o))
        else $error("advance and retard together");
    a_retime_sync: assert property ($changed(retimed_data_o) |-> $fell(rec_clk_o))
        else $error("retimed data off clock edge");
    a_clk_half: assert property ($rose(rec_clk_o) |-> ##[3:5] $fell(rec_clk_o))
        else $error("recovered clock half period");
    c_pulse: cover property ($rose(transition_o));
    c_advance: cover property (advance_o);
    c_retard: cover property (retard_o);
    c_retime: cover property ($changed(retimed_data_o));
endmodule
bind cdr_retime cdr_retime_assertions i_chk (.clock_i(clock_i), .rstn_i(rstn_i),
    .serial_i(serial_i), .rec_clk_o(rec_clk_o), .rec_clk_n_o(rec_clk_n_o),
    .retimed_data_o(retimed_data_o), .transition_o(transition_o), .advance_o(advance_o),
    .retard_o(retard_o), .freq_at_limit_o(freq_at_limit_o));
`default_nettype wire

/* File: nrz_source.sv */
// upstream front end model: prbs nrz source with rate offset and hold
`default_nettype none
module nrz_source (
    input  wire logic       clock_i,
    input  wire logic       en_i,
    input  wire logic       hold_i,
    input  wire logic [7:0] rate_i,
    output logic            serial_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT_UNITS = 100 * cdr_pkg::BIT_CYCLES;
    logic [22:0] lfsr = 23'h7fffff;
    int          acc = 0;
    initial serial_o = 1'b0;
    // fractional accumulator: a 3 percent fast rate needs no odd clock
    always @(negedge clock_i) begin
        if (en_i) begin
            acc += int'(rate_i);
            if (acc >= BIT_UNITS) begin
                acc -= BIT_UNITS;
                lfsr = {lfsr[21:0], lfsr[22] ^ lfsr[17]};
                if (!hold_i) serial_o <= lfsr[0];
            end
        end
    end
endmodule
`default_nettype wire

/* File: cdr_retime_tb.sv */
// self-checking testbench for the clock recovery and retiming block
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module cdr_retime_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clock_i = 1'b0;
    logic       rstn_i = 1'b0;
    logic       tb_data = 1'b0;
    logic       use_model = 1'b0;
    logic       run_en = 1'b0;
    logic       hold = 1'b0;
    logic [7:0] rate = 8'h64;
    int         miscompares = 0;
    int         checks = 0;
    int         n_in, n_out, n_adv, n_ret, n_tr, n_clk;
    wire logic  model_data;
    wire logic  serial = use_model ? model_data : tb_data;
    logic       rclk, rclk_n, retimed, trans, adv, ret, at_lim;
    always #12.5 clock_i = ~clock_i;
    cdr_retime i_dut (.clock_i(clock_i), .rstn_i(rstn_i), .serial_i(serial),
        .rec_clk_o(rclk), .rec_clk_n_o(rclk_n), .retimed_data_o(retimed),
        .transition_o(trans), .advance_o(adv), .retard_o(ret), .freq_at_limit_o(at_lim));
    nrz_source i_src (.clock_i(clock_i), .en_i(run_en), .hold_i(hold), .rate_i(rate),
        .serial_o(model_data));
    function automatic logic near(input int a, input int b, input int t);
        return a >= b - t && a <= b + t;
    endfunction
    // counts are taken at the falling edge, where outputs have settled
    task automatic measure(input int n);
        logic s, r, c;
        {n_in, n_out, n_adv, n_ret, n_tr, n_clk} = '0;
        @(negedge clock_i);
        {s, r, c} = {serial, retimed, rclk};
        repeat (n) begin
            @(negedge clock_i);
            n_in += int'(serial !== s);
            n_out += int'(retimed !== r);
            n_adv += int'(adv === 1'b1);
            n_ret += int'(ret === 1'b1);
            n_tr += int'(trans === 1'b1);
            n_clk += int'(rclk === 1'b1 && c === 1'b0);
            {s, r, c} = {serial, retimed, rclk};
        end
    endtask
    task automatic t_edges();
        repeat (2) begin
            tb_data = ~tb_data;
            measure(12);
            `CHK(n_tr, 2)
            `CHK(n_adv + n_ret, 2)
        end
    endtask
    task automatic t_lock(input logic [7:0] r, input int settle);
        rate <= r;
        use_model = 1'b1;
        run_en <= 1'b1;
        repeat (settle) @(negedge clock_i);
        measure(2000);
        `CHK(at_lim, 1'b0)
        `CHK(near(n_out, n_in, 2), 1'b1)
        `CHK(near(n_adv, n_ret, n_tr / 4), 1'b1)
        `CHK(near(n_clk, 2000 * int'(r) / 800, 3), 1'b1)
    endtask
    task automatic t_hold();
        hold <= 1'b1;
        // let the last edge before the hold leave the pulse pipeline
        repeat (8) @(negedge clock_i);
        measure(400);
        `CHK(n_tr + n_adv + n_ret, 0)
        `CHK(near(n_clk, 400 * int'(rate) / 800, 2), 1'b1)
        hold <= 1'b0;
        t_lock(rate, 400);
    endtask
    task automatic conclude();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clock_i);
        `CHK({rclk_n, rclk, retimed, trans, adv, ret, at_lim}, 7'h40)
        rstn_i = 1'b1;
        measure(200);
        `CHK(n_tr, 0)
        `CHK(n_adv + n_ret, 0)
        t_edges();
        t_lock(8'h64, 6000);
        t_lock(8'h67, 6000);
        t_hold();
        conclude();
    end
endmodule
`default_nettype wire
